// ===== verilog/eeprom_cmd_map.svh
// Purpose: constants of the serial EEPROM command port
// Assumes: sys_clk period in EE_CLK_NS
// Notes: counts derive from printed times
`ifndef EEPROM_CMD_MAP_SVH
`define EEPROM_CMD_MAP_SVH

`define EE_CLK_NS 10
`define EE_PROG_TIME_NS 5000000
`define EE_PROG_CYCLE_COUNT (`EE_PROG_TIME_NS / `EE_CLK_NS)
`define EE_ARRAY_BYTES 1024
`define EE_ABITS_X16 5'h0a
`define EE_ABITS_X8 5'h0b
`define EE_OPBITS 5'h02
`define EE_DBITS_X16 5'h10
`define EE_DBITS_X8 5'h08
`define EE_OP_READ 2'h2
`define EE_OP_ERASE 2'h3
`define EE_OP_WRITE 2'h1
`define EE_OP_EXT 2'h0
`define EE_EXT_ENABLE 2'h3
`define EE_EXT_DISABLE 2'h0
`define EE_EXT_CLEAR_ALL 2'h2
`define EE_EXT_FILL_ALL 2'h1
`define EE_ERASED_WORD 16'hffff
`define EE_ERASED_BYTE 8'hff

`endif

// ===== verilog/eeprom_cmd_pkg.sv
// Purpose: types of the serial EEPROM command port
// Assumes: 1024-byte array
// Notes: all module state except the array lives in port_state_t
package eeprom_cmd_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_HEAD,
		ST_DATA,
		ST_ARMED,
		ST_READ,
		ST_SKIP
	} frame_state_t;

	typedef struct packed {
		logic cs1;
		logic cs2;
		logic cs3;
		logic sk1;
		logic sk2;
		logic sk3;
		logic di1;
		logic di2;
		logic org1;
		logic org2;
		frame_state_t st;
		logic x8;
		logic [4:0] cnt;
		logic [1:0] op;
		logic [10:0] ad;
		logic [15:0] dat;
		logic [9:0] ra;
		logic [15:0] sr;
		logic [4:0] rem;
		logic dout;
		logic oe;
		logic so;
		logic en;
		logic busy;
		logic [31:0] tmr;
		logic show;
		logic hide;
		logic walk;
		logic clr;
		logic [9:0] pbase;
		logic [9:0] wk;
		logic [9:0] wlim;
		logic [15:0] pdat;
	} port_state_t;

endpackage : eeprom_cmd_pkg

// ===== verilog/serial_eeprom_command_port.sv
// Purpose: command decode and array sequencing of a serial EEPROM
// Assumes: pins asynchronous to sys_clk; shift clock far slower than sys_clk
// Notes: reset_n is the power-on detector output
`timescale 1ns/10ps
`include "eeprom_cmd_map.svh"

// How it works
// - Frame is start bit one, opcode, address, then data for writing commands.
// - Header is 13 bits in x16 and 14 bits in x8.
// - Opcode 10 reads, 11 erases, 01 writes; then 10 or 11 address bits.
// - Opcode 00 uses top address bits: enable, disable, clear all, fill all.
// - Serial input bits are sampled on rising shift clock edges.
// - Top address bit is sent by the host but ignored.
// - Output floats except during read data or status.
// - Selected while busy shows low, ready shows high.
// - Dummy one during ready status floats output at next falling clock edge.
// - Read sends one leading zero, then the word MSB first.
// - Read output changes on rising shift clock edges.
// - Continued clocking reads following words, wrapping to address zero.
// - Leading zero appears only before the first word.
// - Deselect after a full write frame starts self-timed clear then store.
// - Single write clears the location before storing.
// - Erase clears one location to all ones.
// - Programming disabled after power-up until enable; disable command turns it off.
// - Reads work whatever the enable latch holds.
// - Clear all sets every bit to one after deselect.
// - Fill all writes the word everywhere without prior clear.
// - Deselect must come before the next rising clock, else nothing is programmed.
// - Power-on reset holds the block; it wakes read-only.
// - Self-timed cycle lasts at most 5 ms.
// - Organization pin high selects x16, low selects x8.
module serial_eeprom_command_port
	import eeprom_cmd_pkg::*;
#(
	parameter int PROG_CYCLES = `EE_PROG_CYCLE_COUNT
)
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic select_line,
	input wire logic serial_shift_clock,
	input wire logic serial_in_line,
	input wire logic org_select,
	output logic serial_out,
	output logic serial_out_oe
);

	generate
		if (PROG_CYCLES < `EE_ARRAY_BYTES + 1)
		begin : g_bad_cycles
			$error("PROG_CYCLES too small to walk the array");
		end
	endgenerate

	// Array has no reset: nonvolatile contents survive power-on reset
	logic [7:0] mem [0:`EE_ARRAY_BYTES-1];
	port_state_t s;
	port_state_t n;
	logic mem_we;
	logic [9:0] mem_wa;
	logic [7:0] mem_wd;
	logic sk_rise;
	logic sk_fall;
	logic cs_fall;
	logic [1:0] ext;
	logic [9:0] dec_addr;

	function automatic logic [15:0] rd_word(input logic [9:0] a, input logic x8);
		if (x8)
			rd_word = {mem[a], 8'h00};
		else
			rd_word = {mem[{a[8:0], 1'b0}], mem[{a[8:0], 1'b1}]};
	endfunction : rd_word

	function automatic logic [4:0] dbits(input logic x8);
		dbits = x8 ? `EE_DBITS_X8 : `EE_DBITS_X16;
	endfunction : dbits

	always_comb
	begin
		n = s;
		mem_we = 1'b0;
		mem_wa = '0;
		mem_wd = '0;
		ext = '0;
		dec_addr = '0;
		n.cs1 = select_line;
		n.cs2 = s.cs1;
		n.cs3 = s.cs2;
		n.sk1 = serial_shift_clock;
		n.sk2 = s.sk1;
		n.sk3 = s.sk2;
		n.di1 = serial_in_line;
		n.di2 = s.di1;
		n.org1 = org_select;
		n.org2 = s.org1;
		sk_rise = s.sk2 & ~s.sk3;
		sk_fall = ~s.sk2 & s.sk3;
		cs_fall = ~s.cs2 & s.cs3;

		if (s.busy)
		begin
			if (s.walk)
			begin
				mem_we = 1'b1;
				mem_wa = 10'(s.pbase + s.wk);
				if (s.clr)
					mem_wd = `EE_ERASED_BYTE;
				else if (s.x8 | mem_wa[0])
					mem_wd = s.pdat[7:0];
				else
					mem_wd = s.pdat[15:8];
				if (s.wk == s.wlim)
				begin
					n.wk = '0;
					if (s.clr)
						n.clr = 1'b0;
					else
						n.walk = 1'b0;
				end
				else
					n.wk = 10'(s.wk + 10'h001);
			end
			if (s.tmr == 32'h00000001)
				n.busy = 1'b0;
			n.tmr = 32'(s.tmr - 32'h00000001);
		end

		if (sk_fall && s.hide)
		begin
			n.show = 1'b0;
			n.hide = 1'b0;
		end

		if (!s.cs2)
		begin
			n.st = ST_IDLE;
			n.hide = 1'b0;
			if (cs_fall && s.st == ST_ARMED && s.en && !s.busy)
			begin
				n.busy = 1'b1;
				n.tmr = 32'(PROG_CYCLES);
				n.show = 1'b1;
				n.walk = 1'b1;
				n.wk = '0;
				n.clr = 1'b0;
				n.pbase = s.x8 ? s.ra : {s.ra[8:0], 1'b0};
				n.wlim = s.x8 ? 10'h000 : 10'h001;
				n.pdat = `EE_ERASED_WORD;
				if (s.op == `EE_OP_WRITE)
				begin
					n.clr = 1'b1;
					n.pdat = s.x8 ? {s.dat[7:0], s.dat[7:0]} : s.dat;
				end
				else if (s.op == `EE_OP_EXT)
				begin
					n.pbase = '0;
					n.wlim = 10'(`EE_ARRAY_BYTES - 1);
					// fill without clear
					// Extended code sits at a different field per organization
					if ((s.x8 ? s.ad[10:9] : s.ad[9:8]) == `EE_EXT_FILL_ALL)
						n.pdat = s.x8 ? {s.dat[7:0], s.dat[7:0]} : s.dat;
				end
			end
		end
		else if (sk_rise)
		begin
			unique case (s.st)
				ST_IDLE:
				begin
					if (s.di2 && !s.busy)
					begin
						n.st = ST_HEAD;
						n.cnt = '0;
						n.x8 = ~s.org2;
						n.hide = s.show;
					end
				end
				ST_HEAD:
				begin
					n.cnt = 5'(s.cnt + 5'h01);
					if (s.cnt < `EE_OPBITS)
						n.op = {s.op[0], s.di2};
					else
						n.ad = {s.ad[9:0], s.di2};
					if (s.cnt == 5'((s.x8 ? `EE_ABITS_X8 : `EE_ABITS_X16) + `EE_OPBITS - 5'h01))
					begin
						ext = s.x8 ? n.ad[10:9] : n.ad[9:8];
						dec_addr = s.x8 ? n.ad[9:0] : {1'b0, n.ad[8:0]};
						n.ra = dec_addr;
						n.cnt = '0;
						n.ad = s.x8 ? n.ad : {1'b0, n.ad[9:0]};
						unique case (n.op)
							`EE_OP_READ:
							begin
								n.st = ST_READ;
								n.dout = 1'b0;
								n.sr = rd_word(dec_addr, s.x8);
								n.rem = dbits(s.x8);
							end
							`EE_OP_ERASE:
								n.st = ST_ARMED;
							`EE_OP_WRITE:
								n.st = ST_DATA;
							`EE_OP_EXT:
							begin
								unique case (ext)
									`EE_EXT_ENABLE:
									begin
										n.en = 1'b1;
										n.st = ST_SKIP;
									end
									`EE_EXT_DISABLE:
									begin
										n.en = 1'b0;
										n.st = ST_SKIP;
									end
									`EE_EXT_CLEAR_ALL:
										n.st = ST_ARMED;
									`EE_EXT_FILL_ALL:
										n.st = ST_DATA;
								endcase
							end
						endcase
					end
				end
				ST_DATA:
				begin
					n.dat = {s.dat[14:0], s.di2};
					n.cnt = 5'(s.cnt + 5'h01);
					if (s.cnt == 5'(dbits(s.x8) - 5'h01))
						n.st = ST_ARMED;
				end
				ST_ARMED:
				begin
					n.st = ST_SKIP;
				end
				ST_READ:
				begin
					n.dout = s.sr[15];
					if (s.rem == 5'h01)
					begin
						n.ra = s.x8 ? 10'(s.ra + 10'h001) : {1'b0, 9'(s.ra[8:0] + 9'h001)};
						n.sr = rd_word(n.ra, s.x8);
						n.rem = dbits(s.x8);
					end
					else
					begin
						n.sr = {s.sr[14:0], 1'b0};
						n.rem = 5'(s.rem - 5'h01);
					end
				end
				ST_SKIP:
				begin
					n.st = ST_SKIP;
				end
			endcase
		end

		n.oe = s.cs2 & (n.st == ST_READ | n.busy | n.show);
		n.so = (n.st == ST_READ) ? n.dout : ~n.busy;
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			s <= '0;
		else
			s <= n;
	end

	always_ff @(posedge sys_clk)
	begin
		if (mem_we)
			mem[mem_wa] <= mem_wd;
	end

	assign serial_out = s.so;
	assign serial_out_oe = s.oe;

endmodule : serial_eeprom_command_port

// ===== tb/serial_eeprom_port_monitor.sv
// Purpose: port checks of the serial EEPROM command port
// Assumes: host keeps its shift clock low whenever select changes
// Notes: a low status run is bounded by the program time
`timescale 1ns/10ps
module serial_eeprom_port_monitor #(
	parameter int PROG_CYCLES = 2000
)
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic select_line,
	input wire logic serial_shift_clock,
	input wire logic serial_in_line,
	input wire logic org_select,
	input wire logic serial_out,
	input wire logic serial_out_oe
);
	int lo_cnt;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			lo_cnt <= 0;
		else
			lo_cnt <= (serial_out_oe && !serial_out) ? lo_cnt + 1 : 0;
	end
	a_wake_quiet: assert property ($rose(reset_n) |-> !serial_out_oe)
		else $error("output enabled at wake");
	a_float_idle: assert property (!select_line [*8] |-> !serial_out_oe)
		else $error("output driven while deselected");
	a_rise_selected: assert property ($rose(serial_out_oe) |-> select_line)
		else $error("output enabled without select");
	a_lead_zero: assert property ($rose(serial_out_oe) && serial_shift_clock |-> !serial_out)
		else $error("read began without leading zero");
	a_fall_on_rise: assert property ($fell(serial_out) && serial_out_oe && $past(serial_out_oe)
		|-> serial_shift_clock)
		else $error("read bit changed off the rising clock");
	a_hide_on_fall: assert property ($fell(serial_out_oe) && select_line |-> !serial_shift_clock)
		else $error("status hidden off the falling clock");
	a_read_holds: assert property (serial_out_oe && select_line && serial_shift_clock
		|=> serial_out_oe)
		else $error("output dropped mid read");
	a_busy_bound: assert property (lo_cnt < PROG_CYCLES + 100)
		else $error("busy status lasted too long");
	c_read: cover property ($rose(serial_out_oe) && serial_shift_clock);
	c_hide: cover property ($fell(serial_out_oe) && select_line);
	c_busy: cover property (lo_cnt == 1000);
endmodule : serial_eeprom_port_monitor

bind serial_eeprom_command_port serial_eeprom_port_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_monitor (
	.sys_clk(sys_clk), .reset_n(reset_n), .select_line(select_line),
	.serial_shift_clock(serial_shift_clock), .serial_in_line(serial_in_line),
	.org_select(org_select), .serial_out(serial_out), .serial_out_oe(serial_out_oe));

// ===== tb/eeprom_host_model.sv
// Purpose: serial host driving the command port
// Assumes: 160 ns shift clock, stopped outside frames
// Notes: captures the output line just before each falling clock
`timescale 1ns/10ps
module eeprom_host_model (
	output logic select_line,
	output logic serial_shift_clock,
	output logic serial_in_line,
	input wire logic serial_out,
	input wire logic serial_out_oe
);
	logic [63:0] rx = '0;
	initial
	begin
		select_line = 0;
		serial_shift_clock = 0;
		serial_in_line = 0;
	end
	task automatic frame(input logic [63:0] v, input int n);
		select_line = 1;
		#80;
		for (int i = n - 1; i >= 0; i--)
		begin
			serial_in_line = v[i];
			#80 serial_shift_clock = 1;
			#70 rx = {rx[62:0], serial_out};
			#10 serial_shift_clock = 0;
		end
		#20 select_line = 0;
		serial_in_line = ~serial_in_line;
		#400;
	endtask : frame
	task automatic poll(output logic [1:0] first, output int waited, output logic hid);
		select_line = 1;
		#160 first = {serial_out_oe, serial_out};
		waited = 0;
		while (!(serial_out_oe === 1'b1 && serial_out === 1'b1) && waited < 2200)
		begin
			#10 waited++;
		end
		serial_in_line = 1;
		#80 serial_shift_clock = 1;
		#80 serial_shift_clock = 0;
		#100 hid = serial_out_oe;
		select_line = 0;
		serial_in_line = 0;
		#400;
	endtask : poll
endmodule : eeprom_host_model

// ===== tb/serial_eeprom_command_port_bench.sv
// Purpose: self-checking bench of the serial EEPROM command port
// Assumes: x16 organization except in t_byte_org, short program time
// Notes: array starts unknown, so it is filled first
`timescale 1ns/10ps
`define CHECK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("unexpected %s expected %h seen %h", nm, exp, got); end end
module serial_eeprom_command_port_bench;
	logic sys_clk = 0;
	logic reset_n = 0;
	logic org_select = 1;
	logic select_line, serial_shift_clock, serial_in_line, serial_out, serial_out_oe;
	int n_mismatch = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [1:0] first;
	int waited;
	logic hid;
	always #5 sys_clk = ~sys_clk;
	serial_eeprom_command_port #(.PROG_CYCLES(2000)) u_dut (.sys_clk(sys_clk),
		.reset_n(reset_n), .select_line(select_line), .serial_shift_clock(serial_shift_clock),
		.serial_in_line(serial_in_line), .org_select(org_select), .serial_out(serial_out),
		.serial_out_oe(serial_out_oe));
	eeprom_host_model u_host (.select_line(select_line), .serial_shift_clock(serial_shift_clock),
		.serial_in_line(serial_in_line), .serial_out(serial_out), .serial_out_oe(serial_out_oe));
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test
	task automatic prog(input logic [63:0] v, input int n);
		u_host.frame(v, n);
		u_host.poll(first, waited, hid);
		`CHECK("busy status", 2'b10, first)
		`CHECK("ready in time", 1'b1, waited < 2100)
		`CHECK("status hidden", 1'b0, hid)
	endtask : prog
	task automatic read_top(input logic [32:0] exp);
		u_host.frame({13'h19ff, 32'h0}, 45);
		`CHECK("read stream", exp, u_host.rx[32:0])
	endtask : read_top
	task automatic t_fill_write;
		u_host.frame(13'h1300, 13);
		prog({13'h1100, 16'h1234}, 29);
		prog({13'h15ff, 16'ha5c3}, 29);
		read_top({1'b0, 16'ha5c3, 16'h1234});
		$display("done t_fill_write");
	endtask : t_fill_write
	task automatic t_erase;
		prog(13'h1e00, 13);
		read_top({1'b0, 16'ha5c3, 16'hffff});
		$display("done t_erase");
	endtask : t_erase
	task automatic t_clear;
		prog(13'h1200, 13);
		read_top({1'b0, 16'hffff, 16'hffff});
		$display("done t_clear");
	endtask : t_clear
	task automatic t_locked;
		u_host.frame(13'h1000, 13);
		u_host.frame({13'h15ff, 16'h0000}, 29);
		u_host.poll(first, waited, hid);
		`CHECK("no program start", 1'b0, first[1])
		read_top({1'b0, 16'hffff, 16'hffff});
		$display("done t_locked");
	endtask : t_locked
	task automatic t_byte_org;
		org_select = 0;
		u_host.frame(14'h2600, 14);
		prog({14'h2fff, 8'h5a}, 22);
		u_host.frame({14'h2fff, 8'h00, 1'b0}, 23);
		u_host.poll(first, waited, hid);
		`CHECK("late drop ignored", 1'b0, first[1])
		u_host.frame({14'h37ff, 16'h0}, 30);
		`CHECK("byte read", {1'b0, 8'h5a, 8'hff}, u_host.rx[16:0])
		org_select = 1;
		$display("done t_byte_org");
	endtask : t_byte_org
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			n_mismatch++;
			end_of_test();
		end
	end
	initial
	begin
		repeat (3) @(posedge sys_clk);
		#1 reset_n = 1;
		repeat (4) @(posedge sys_clk);
		// Keep every host edge just after a sys_clk rise
		#1;
		t_fill_write();
		t_erase();
		t_clear();
		t_locked();
		t_byte_org();
		end_of_test();
	end
endmodule : serial_eeprom_command_port_bench
